// [mqf_pkg.sv]
package mqf_pkg;

  // ============================================================
  // Geometry of the queue device.
  localparam int              DATA_W     = 36;
  localparam int              NUM_Q      = 4;
  localparam int              QDEPTH     = 8;
  localparam int              PTR_W      = 3;
  localparam int              CNT_W      = 4;
  localparam int              ADDR_W     = 5;
  localparam int              DEV_W      = 3;

  // ============================================================
  // Serial configuration stream: fixed head plus one block per queue.
  localparam int              CFG_HEAD_BITS = 19;
  localparam int              CFG_Q_BITS    = 72;
  localparam int              CFG_CNT_W     = 9;
  localparam logic [1:0]      DFLT_QSEL     = 2'h3;

  // ============================================================
  // Fall-through timing after a read queue change, in read clocks.
  localparam logic [1:0]      FALL_FIRST_CYC = 2'h2;

  // ============================================================
  // Host register offsets (byte addresses) and reset values.
  localparam logic [7:0]      OFS_WQSEL  = 8'h00;
  localparam logic [7:0]      OFS_RQSEL  = 8'h04;
  localparam logic [7:0]      OFS_WDATA  = 8'h08;
  localparam logic [7:0]      OFS_RDATA  = 8'h0C;
  localparam logic [7:0]      OFS_STATUS = 8'h10;
  localparam logic [7:0]      OFS_SERIAL = 8'h14;
  localparam int              ST_DONE    = 0;
  localparam int              ST_FULL_N  = 1;
  localparam int              ST_VALID_N = 2;
  localparam int              ST_BLOCKED = 3;
  localparam int              SER_DATA   = 0;
  localparam int              SER_CLK    = 1;
  localparam int              SER_EN_N   = 2;
  localparam logic [2:0]      SER_RESET  = 3'h4;

  // ============================================================
  // State encodings (Gray on each step but the default-mode wait-to-done jump and the fill-to-idle return).
  typedef enum logic [1:0] {
    CFG_WAIT  = 2'h0,
    CFG_SHIFT = 2'h1,
    CFG_DONE  = 2'h3
  } mqf_cfg_type;

  typedef enum logic [1:0] {
    RSW_IDLE  = 2'h0,
    RSW_DRAIN = 2'h1,
    RSW_FILL  = 2'h3
  } mqf_rsw_type;

endpackage : mqf_pkg

// [mqf_if.sv]
`timescale 1ns/1ns
interface mqf_if;
  import mqf_pkg::*;

  // ============================================================
  // Configuration chain, write port, read port of one device.
  logic                  serial_clk;
  logic                  serial_in;
  logic                  chain_enable_in;
  logic                  serial_out;
  logic                  chain_done_out;
  logic                  wr_qsel;
  logic [ADDR_W-1:0]     wr_qaddr;
  logic                  wr_en_n;
  logic [DATA_W-1:0]     din;
  logic                  queue_full_flag;
  logic                  queue_full_flag_oe;
  logic                  rd_qsel;
  logic [ADDR_W-1:0]     rd_qaddr;
  logic                  rd_en_n;
  logic [DATA_W-1:0]     dout;
  logic                  dout_oe;
  logic                  output_valid_flag;
  logic                  output_valid_flag_oe;

  modport dev (
    input  serial_clk, serial_in, chain_enable_in,
    output serial_out, chain_done_out,
    input  wr_qsel, wr_qaddr, wr_en_n, din,
    output queue_full_flag, queue_full_flag_oe,
    input  rd_qsel, rd_qaddr, rd_en_n,
    output dout, dout_oe, output_valid_flag, output_valid_flag_oe
  );

  modport host (
    output serial_clk, serial_in, chain_enable_in,
    input  chain_done_out,
    output wr_qsel, wr_qaddr, wr_en_n, din,
    input  queue_full_flag,
    output rd_qsel, rd_qaddr, rd_en_n,
    input  dout, output_valid_flag
  );

endinterface : mqf_if

// [mqf_cfg_loader.sv]
`timescale 1ns/1ns
module mqf_cfg_loader
  import mqf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        default_program_select,
  input  wire logic        default_density_select,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  input  wire logic        chain_enable_in,
  output logic             serial_out,
  output logic             chain_done_out,
  output logic             cfg_done,
  output logic [1:0]       cfg_qmax,
  output logic             cfg_half_depth
);

  mqf_cfg_type           st_r;
  logic                  sclk_d_r;
  logic [CFG_CNT_W-1:0]  bits_r;
  logic [CFG_CNT_W-1:0]  len;
  logic                  shift;

  // Stream length follows the queue count carried in its first two bits.
  assign len   = CFG_CNT_W'(CFG_HEAD_BITS)
               + CFG_CNT_W'(CFG_Q_BITS) * CFG_CNT_W'({1'b0, cfg_qmax} + 3'h1);
  assign shift = (st_r == CFG_SHIFT) && serial_clk && !sclk_d_r
               && !chain_enable_in;
  assign cfg_done = (st_r == CFG_DONE);

  // ============================================================
  // Serial clock sampled as a plain synchronous input.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= serial_clk;
    end
  end

  // ============================================================
  // Mode strap is caught on the first edge after reset release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r           <= CFG_WAIT;
      bits_r         <= '0;
      cfg_qmax       <= DFLT_QSEL;
      cfg_half_depth <= 1'b0;
    end else begin
      unique case (st_r)
        CFG_WAIT: begin
          if (default_program_select) begin
            st_r           <= CFG_DONE;
            cfg_half_depth <= default_density_select;
          end else begin
            st_r <= CFG_SHIFT;
          end
        end
        CFG_SHIFT: begin
          if (shift) begin
            bits_r <= bits_r + CFG_CNT_W'(1);
            if (bits_r < CFG_CNT_W'(2)) begin
              cfg_qmax <= {cfg_qmax[0], serial_in};
            end
            if (bits_r >= CFG_CNT_W'(2) && bits_r == len - CFG_CNT_W'(1)) begin
              st_r <= CFG_DONE;
            end
          end
        end
        CFG_DONE: st_r <= CFG_DONE;
        default:  st_r <= CFG_WAIT;
      endcase
    end
  end

  // ============================================================
  // Once configured the chain pins pass straight through, one flop late.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chain_done_out <= 1'b1;
      serial_out     <= 1'b0;
    end else if (cfg_done) begin
      // done low propagates to last device
      chain_done_out <= chain_enable_in;
      serial_out     <= serial_in;
    end
  end

endmodule : mqf_cfg_loader

// [mqf_device.sv]
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
// What this block does
// - Host waits for final chain done low.
// - Configured device passes enable and data through.
// - Strap low at reset selects serial mode.
// - Finished chain ignores further serial loading.
// - Final device drives chain done low.
// - Default mode works with serial clock tied.
// - Chain done feeds next device enable.
// - Stream holds 19 bits plus 72 per queue.
// - No write stored while full flag low.
// - Filling write drives full flag low.
// - Full flag follows new write queue next cycle.
// - Read from full queue raises full flag.
// - First word falls through after one clock.
// - Queue change drains one more old word.
// - New queue word appears two clocks later.
// - Output holds when reads disabled.
// - Valid flag high after read to empty.
// - Fallen-through word marks valid flag low.
// - Write to empty selected queue shows word.
// - Deselected device floats full flag.
// - Read owner drives data and valid flag.
module mqf_device
  import mqf_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  mqf_if.dev                      link,
  input  wire logic [DEV_W-1:0]   device_id,
  input  wire logic               default_program_select,
  input  wire logic               default_density_select,
  output logic                    cfg_done_o,
  output logic                    wr_owner_o,
  output logic                    rd_owner_o
);

  logic                     cfg_done;
  logic [1:0]               cfg_qmax;
  logic                     cfg_half;
  logic [CNT_W-1:0]         lim;
  logic [DATA_W-1:0]        mem_r [NUM_Q][QDEPTH];
  logic [PTR_W-1:0]         wp_r  [NUM_Q];
  logic [PTR_W-1:0]         rp_r  [NUM_Q];
  logic [CNT_W-1:0]         cnt_r [NUM_Q];
  logic [CNT_W-1:0]         cnt_nxt [NUM_Q];
  logic                     wr_own_r;
  logic [1:0]               wr_q_r;
  logic                     rd_own_r;
  logic [1:0]               rd_q_r;
  logic                     pend_own_r;
  logic [1:0]               pend_q_r;
  mqf_rsw_type              rsw_r;
  logic                     want;
  logic                     wr_fire;
  logic                     rd_pop;

  mqf_cfg_loader u_cfg (
    .mclk                   (mclk),
    .resetn                 (resetn),
    .default_program_select (default_program_select),
    .default_density_select (default_density_select),
    .serial_clk             (link.serial_clk),
    .serial_in              (link.serial_in),
    .chain_enable_in        (link.chain_enable_in),
    .serial_out             (link.serial_out),
    .chain_done_out         (link.chain_done_out),
    .cfg_done               (cfg_done),
    .cfg_qmax               (cfg_qmax),
    .cfg_half_depth         (cfg_half)
  );

  // Half-depth default trades capacity for shorter flag latency tests.
  assign lim = cfg_half ? CNT_W'(QDEPTH / 2) : CNT_W'(QDEPTH);

  // ============================================================
  // Write acceptance. The count check also covers the one cycle in
  // which the flag still shows the previous queue.
  // full blocks storage
  assign wr_fire = cfg_done && wr_own_r && !link.wr_en_n
                && link.queue_full_flag && (wr_q_r <= cfg_qmax)
                && (cnt_r[wr_q_r] < lim);

  // ============================================================
  // Read demand: enabled read, forced fall-through, or empty output.
  // forced drain of old queue
  assign want   = (rsw_r != RSW_IDLE) || !link.rd_en_n
               || link.output_valid_flag;
  assign rd_pop = cfg_done && rd_own_r && want && (rd_q_r <= cfg_qmax)
               && (cnt_r[rd_q_r] != '0);

  // ============================================================
  // Per-queue pointers and occupancy.
  for (genvar q = 0; q < NUM_Q; q++) begin : g_q
    logic push;
    logic pop;
    assign push = wr_fire && (wr_q_r == 2'(q));
    assign pop  = rd_pop && (rd_q_r == 2'(q));
    assign cnt_nxt[q] = cnt_r[q] + CNT_W'(push) - CNT_W'(pop);

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        wp_r[q]  <= '0;
        rp_r[q]  <= '0;
        cnt_r[q] <= '0;
      end else begin
        cnt_r[q] <= cnt_nxt[q];
        if (push) begin
          wp_r[q] <= wp_r[q] + PTR_W'(1);
        end
        if (pop) begin
          rp_r[q] <= rp_r[q] + PTR_W'(1);
        end
      end
    end

    // Storage has no reset; only written words are ever read.
    always_ff @(posedge mclk) begin
      if (push) begin
        mem_r[q][wp_r[q]] <= link.din;
      end
    end
  end

  // ============================================================
  // Write queue selection and full flag.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_own_r <= 1'b0;
      wr_q_r   <= '0;
    end else if (cfg_done && link.wr_qsel) begin
      wr_own_r <= (link.wr_qaddr[ADDR_W-1:2] == device_id);
      wr_q_r   <= link.wr_qaddr[1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.queue_full_flag    <= 1'b1;
      link.queue_full_flag_oe <= 1'b0;
    end else begin
      link.queue_full_flag    <= (cnt_nxt[wr_q_r] < lim);
      link.queue_full_flag_oe <= wr_own_r;
    end
  end

  // ============================================================
  // Read queue switch: one drain cycle, then the new queue feeds.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsw_r      <= RSW_IDLE;
      rd_own_r   <= 1'b0;
      rd_q_r     <= '0;
      pend_own_r <= 1'b0;
      pend_q_r   <= '0;
    end else begin
      unique case (rsw_r)
        RSW_IDLE: begin
          if (cfg_done && link.rd_qsel) begin
            pend_own_r <= (link.rd_qaddr[ADDR_W-1:2] == device_id);
            pend_q_r   <= link.rd_qaddr[1:0];
            rsw_r      <= RSW_DRAIN;
          end
        end
        RSW_DRAIN: begin
          rd_own_r <= pend_own_r;
          rd_q_r   <= pend_q_r;
          rsw_r    <= RSW_FILL;
        end
        RSW_FILL: begin
          if (cfg_done && link.rd_qsel) begin
            pend_own_r <= (link.rd_qaddr[ADDR_W-1:2] == device_id);
            pend_q_r   <= link.rd_qaddr[1:0];
            rsw_r      <= RSW_DRAIN;
          end else begin
            rsw_r <= RSW_IDLE;
          end
        end
        default: rsw_r <= RSW_IDLE;
      endcase
    end
  end

  // ============================================================
  // Output register and valid flag (low means valid).
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.dout              <= '0;
      link.output_valid_flag <= 1'b1;
    end else if (rd_pop) begin
      link.dout              <= mem_r[rd_q_r][rp_r[rd_q_r]];
      link.output_valid_flag <= 1'b0;
    end else if (rd_own_r && want && rsw_r != RSW_DRAIN) begin
      link.output_valid_flag <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.dout_oe              <= 1'b0;
      link.output_valid_flag_oe <= 1'b0;
    end else begin
      link.dout_oe              <= rd_own_r;
      link.output_valid_flag_oe <= rd_own_r;
    end
  end

  // Status mirrors for the local user side.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_done_o <= 1'b0;
      wr_owner_o <= 1'b0;
      rd_owner_o <= 1'b0;
    end else begin
      cfg_done_o <= cfg_done;
      wr_owner_o <= wr_own_r;
      rd_owner_o <= rd_own_r;
    end
  end

endmodule : mqf_device

// [mqf_host.sv]
`timescale 1ns/1ns
module mqf_host
  import mqf_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               resetn,
  mqf_if.host                     link,
  input  wire logic [7:0]         addr,
  input  wire logic [DATA_W-1:0]  wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [DATA_W-1:0]       rdata
);

  logic  done_r;
  logic  blocked_r;
  logic  cmd;
  logic  cmd_early;

  // Port commands are only issued after the whole chain is configured.
  assign cmd = (wr && (addr == OFS_WQSEL || addr == OFS_RQSEL
                    || addr == OFS_WDATA))
            || (rd && addr == OFS_RDATA);
  assign cmd_early = cmd && !done_r;

  // ============================================================
  // Completion seen on the last device's chain done output.
  // last chain done is completion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_r    <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      done_r <= !link.chain_done_out;
      // Sticky, cleared by any status write; a new refusal wins.
      if (cmd_early) begin
        blocked_r <= 1'b1;
      end else if (wr && addr == OFS_STATUS) begin
        blocked_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Bit-banged configuration pins.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.serial_in       <= SER_RESET[SER_DATA];
      link.serial_clk      <= SER_RESET[SER_CLK];
      link.chain_enable_in <= SER_RESET[SER_EN_N];
    end else if (wr && addr == OFS_SERIAL) begin
      link.serial_in       <= wdata[SER_DATA];
      link.serial_clk      <= wdata[SER_CLK];
      link.chain_enable_in <= wdata[SER_EN_N];
    end
  end

  // ============================================================
  // Queue selection strobes, one cycle each.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.wr_qsel  <= 1'b0;
      link.rd_qsel  <= 1'b0;
      link.wr_qaddr <= '0;
      link.rd_qaddr <= '0;
    end else begin
      link.wr_qsel <= done_r && wr && addr == OFS_WQSEL;
      link.rd_qsel <= done_r && wr && addr == OFS_RQSEL;
      if (done_r && wr && addr == OFS_WQSEL) begin
        link.wr_qaddr <= wdata[ADDR_W-1:0];
      end
      if (done_r && wr && addr == OFS_RQSEL) begin
        link.rd_qaddr <= wdata[ADDR_W-1:0];
      end
    end
  end

  // ============================================================
  // Word write and read-advance enables, active low, one cycle.
  // The device drops writes while full, so software checks status.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      link.wr_en_n <= 1'b1;
      link.rd_en_n <= 1'b1;
      link.din     <= '0;
    end else begin
      link.wr_en_n <= !(done_r && wr && addr == OFS_WDATA);
      link.rd_en_n <= !(done_r && rd && addr == OFS_RDATA);
      if (done_r && wr && addr == OFS_WDATA) begin
        link.din <= wdata;
      end
    end
  end

  // ============================================================
  // Read data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= '0;
      unique case (addr)
        OFS_RDATA: rdata <= link.dout;
        OFS_STATUS: begin
          rdata[ST_DONE]    <= done_r;
          rdata[ST_FULL_N]  <= link.queue_full_flag;
          rdata[ST_VALID_N] <= link.output_valid_flag;
          rdata[ST_BLOCKED] <= blocked_r;
        end
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule : mqf_host

// [mqf_assertions.sv]
`timescale 1ns/1ns
module mqf_assertions
  import mqf_pkg::*;
#(
  parameter logic [DEV_W-1:0] OWN_ID = 3'h0
)(
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic              default_mode,
  input wire logic              serial_in,
  input wire logic              chain_enable_in,
  input wire logic              serial_out,
  input wire logic              chain_done_out,
  input wire logic              wr_qsel,
  input wire logic [ADDR_W-1:0] wr_qaddr,
  input wire logic              wr_en_n,
  input wire logic              queue_full_flag_oe,
  input wire logic              rd_qsel,
  input wire logic [ADDR_W-1:0] rd_qaddr,
  input wire logic              rd_en_n,
  input wire logic [DATA_W-1:0] dout,
  input wire logic              dout_oe,
  input wire logic              output_valid_flag,
  input wire logic              output_valid_flag_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ============================================================
  // Selection steps: a select pulse followed by a quiet cycle.
  sequence s_own_wsel;
    wr_qsel && (wr_qaddr[4:2] == OWN_ID) ##1 !wr_qsel;
  endsequence
  sequence s_oth_wsel;
    wr_qsel && (wr_qaddr[4:2] != OWN_ID) ##1 !wr_qsel;
  endsequence
  sequence s_own_rsel;
    rd_qsel && (rd_qaddr[4:2] == OWN_ID) ##1 !rd_qsel;
  endsequence

  // ============================================================
  // Chain behaviour and command gating.
  property p_cmd_after_done;
    (wr_qsel || rd_qsel || !wr_en_n || !rd_en_n) |-> !$past(chain_done_out);
  endproperty
  a_cmd_after_done: assert property (p_cmd_after_done)
    else $error("port activity before chain done");
  property p_chain_pass;
    !chain_done_out |=> (chain_done_out == $past(chain_enable_in))
                        && (serial_out == $past(serial_in));
  endproperty
  a_chain_pass: assert property (p_chain_pass)
    else $error("chain pass-through broken");
  property p_done_low;
    default_mode && $fell(chain_enable_in) |-> ##[1:3] !chain_done_out;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("chain done did not go low");

  // ============================================================
  // Ownership of shared flags and data bus.
  property p_full_owner;
    s_own_wsel |=> queue_full_flag_oe;
  endproperty
  a_full_owner: assert property (p_full_owner)
    else $error("full flag not driven by owner");
  property p_full_float;
    s_oth_wsel |=> !queue_full_flag_oe;
  endproperty
  a_full_float: assert property (p_full_float)
    else $error("full flag not floated");
  property p_rd_owner;
    // The enables trail the owner flop, which trails the drain cycle.
    s_own_rsel |=> ##1 (dout_oe && output_valid_flag_oe);
  endproperty
  a_rd_owner: assert property (p_rd_owner)
    else $error("read owner not driving outputs");

  // ============================================================
  // Output register and valid flag.
  property p_hold;
    rd_en_n && !output_valid_flag && !rd_qsel && !$past(rd_qsel)
      && !$past(rd_qsel, 2) |=> $stable(dout);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without demand");
  property p_last_stays;
    $rose(output_valid_flag) |-> $stable(dout);
  endproperty
  a_last_stays: assert property (p_last_stays)
    else $error("last word lost on empty");
  property p_new_valid;
    dout_oe && $changed(dout) |-> !output_valid_flag;
  endproperty
  a_new_valid: assert property (p_new_valid)
    else $error("new word not marked valid");
endmodule : mqf_assertions

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import mqf_pkg::*;
  logic              mclk;
  logic              resetn;
  logic [7:0]        addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  int                fails;
  int                compares;
  logic              dflt;

  // ============================================================
  // Two ends joined by the link; one device at id zero. The strap picks
  // default mode first and serial mode after a second reset.
  mqf_if link_if();
  mqf_device mqf_device_inst (.mclk(mclk), .resetn(resetn),
    .link(link_if), .device_id(3'h0), .default_program_select(dflt),
    .default_density_select(1'b0), .cfg_done_o(), .wr_owner_o(),
    .rd_owner_o());
  mqf_host mqf_host_inst (.mclk(mclk), .resetn(resetn), .link(link_if),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  mqf_assertions #(.OWN_ID(3'h0)) mqf_assertions_inst (.mclk(mclk),
    .resetn(resetn), .default_mode(dflt), .serial_in(link_if.serial_in),
    .chain_enable_in(link_if.chain_enable_in),
    .serial_out(link_if.serial_out), .chain_done_out(link_if.chain_done_out),
    .wr_qsel(link_if.wr_qsel), .wr_qaddr(link_if.wr_qaddr),
    .wr_en_n(link_if.wr_en_n), .queue_full_flag_oe(link_if.queue_full_flag_oe),
    .rd_qsel(link_if.rd_qsel), .rd_qaddr(link_if.rd_qaddr),
    .rd_en_n(link_if.rd_en_n), .dout(link_if.dout), .dout_oe(link_if.dout_oe),
    .output_valid_flag(link_if.output_valid_flag),
    .output_valid_flag_oe(link_if.output_valid_flag_oe));

  // Free-running 125 MHz clock.
  always #4 mclk = ~mclk;

  // ============================================================
  // Access tasks for the register port.
  task automatic wr_reg(input logic [7:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_reg(input logic [7:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  task automatic chk(input logic [DATA_W-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] v;
    rd_reg(OFS_RDATA, v);
    chk(v, exp);
  endtask : chk_rd

  task automatic chk_st(input int b, input logic e);
    logic [DATA_W-1:0] v;
    rd_reg(OFS_STATUS, v);
    chk(DATA_W'(v[b]), DATA_W'(e));
  endtask : chk_st

  function automatic logic [DATA_W-1:0] wd(input int q, input int i);
    return DATA_W'(32'h5A5A0000 + q * 256 + i);
  endfunction : wd

  task automatic print_verdict;
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // ============================================================
  // Main sequence.
  initial begin
    mclk   = 1'b0;
    resetn = 1'b0;
    addr   = 8'h00;
    wdata  = '0;
    wr     = 1'b0;
    rd     = 1'b0;
    dflt   = 1'b1;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    idle(2);
    wr_reg(OFS_WQSEL, 36'h0);
    chk_st(ST_BLOCKED, 1'b1);
    chk_st(ST_DONE, 1'b0);
    wr_reg(OFS_SERIAL, 36'h0);
    idle(4);
    chk_st(ST_DONE, 1'b1);
    // Toggle clock and data only; the enable stays low throughout.
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_SERIAL, DATA_W'(k));
    end
    chk_st(ST_DONE, 1'b1);
    wr_reg(OFS_WQSEL, 36'h04);
    idle(3);
    wr_reg(OFS_RQSEL, 36'h0);
    wr_reg(OFS_WQSEL, 36'h0);
    idle(3);
    chk_st(ST_VALID_N, 1'b1);
    // The first word falls into the output register, so one word more
    // than the queue depth is needed before the queue reads full.
    for (int i = 0; i <= QDEPTH; i++) begin
      wr_reg(OFS_WDATA, wd(0, i));
    end
    idle(4);
    chk_st(ST_FULL_N, 1'b0);
    chk_st(ST_VALID_N, 1'b0);
    wr_reg(OFS_WDATA, 36'h0DEADBEEF);
    wr_reg(OFS_WQSEL, 36'h01);
    idle(3);
    chk_st(ST_FULL_N, 1'b1);
    wr_reg(OFS_WDATA, wd(1, 0));
    wr_reg(OFS_WDATA, wd(1, 1));
    wr_reg(OFS_WQSEL, 36'h0);
    idle(3);
    chk_st(ST_FULL_N, 1'b0);
    chk_rd(wd(0, 0));
    idle(4);
    chk_st(ST_FULL_N, 1'b1);
    wr_reg(OFS_RQSEL, 36'h01);
    idle(4);
    chk_rd(wd(1, 0));
    idle(3);
    chk_rd(wd(1, 1));
    idle(3);
    chk_st(ST_VALID_N, 1'b1);
    chk_rd(wd(1, 1));
    wr_reg(OFS_RQSEL, 36'h0);
    idle(4);
    chk_rd(wd(0, 3));
    idle(10);
    chk_rd(wd(0, 4));
    wr_reg(OFS_RQSEL, 36'h01);
    wr_reg(OFS_WQSEL, 36'h01);
    idle(4);
    chk_st(ST_VALID_N, 1'b1);
    wr_reg(OFS_WDATA, wd(1, 2));
    idle(4);
    chk_st(ST_VALID_N, 1'b0);
    chk_rd(wd(1, 2));
    // ============================================================
    // Second reset with the strap low: serial mode. Two leading zero
    // bits give one queue, so the stream is the head plus one block.
    idle(1);
    resetn <= 1'b0;
    dflt   <= 1'b0;
    idle(2);
    resetn <= 1'b1;
    idle(2);
    for (int k = 1; k < CFG_HEAD_BITS + CFG_Q_BITS; k++) begin
      wr_reg(OFS_SERIAL, 36'h0);
      wr_reg(OFS_SERIAL, 36'h2);
    end
    idle(4);
    chk_st(ST_DONE, 1'b0);
    wr_reg(OFS_SERIAL, 36'h0);
    wr_reg(OFS_SERIAL, 36'h2);
    idle(4);
    chk_st(ST_DONE, 1'b1);
    // A further shift edge after completion must leave the chain done.
    wr_reg(OFS_SERIAL, 36'h1);
    wr_reg(OFS_SERIAL, 36'h3);
    idle(4);
    chk_st(ST_DONE, 1'b1);
    print_verdict();
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    print_verdict();
  end
endmodule : tb_top
